// File: include/pmcs_params.svh
// constants of the power-mode and clock supervisor: offsets, fields, resets, timing
// assumes a 20 MHz register clock; included by its bare name
`ifndef PMCS_PARAMS_SVH
`define PMCS_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PMCS_CLK_PERIOD_NS 50
`define PMCS_REG_SETTLE_NS 500
`define PMCS_REG_SETTLE_CYC ((`PMCS_REG_SETTLE_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)
`define PMCS_RC_START_NS 2000
`define PMCS_RC_START_CYC ((`PMCS_RC_START_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMCS_ADR_CTRL 8'h00
`define PMCS_ADR_STAT 8'h04

// ----------------------------------------
// control fields
// ----------------------------------------
`define PMCS_CTRL_MODE_LSB 0
`define PMCS_CTRL_STOP_LP 2
`define PMCS_CTRL_PVD_EN 3
`define PMCS_CTRL_PVD_FALL 4
`define PMCS_CTRL_PVD_RISE 5
`define PMCS_CTRL_FAIL_IE 6
`define PMCS_CTRL_EXT_SEL 7
`define PMCS_CTRL_AHB_LSB 8
`define PMCS_CTRL_APB_LSB 12
`define PMCS_CTRL_PLL_EN 15
`define PMCS_CTRL_RST 16'h0000

// ----------------------------------------
// status fields
// ----------------------------------------
`define PMCS_STAT_PVD_FLAG 9
`define PMCS_STAT_FAIL_FLAG 10

`endif

// File: include/pmcs_pkg.sv
// types of the power-mode and clock supervisor
// assumes nothing beyond a SystemVerilog compiler
package pmcs_pkg;

	// ----------------------------------------
	// supervisor states, one-hot
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_SLEEP = 6'h02,
		ST_STOP = 6'h04,
		ST_WAKE = 6'h08,
		ST_STBY = 6'h10,
		ST_SPARE = 6'h20
	} pmcs_state_t;

	// ----------------------------------------
	// low-power mode chosen by software
	// ----------------------------------------
	typedef enum logic [1:0] {
		LP_SLEEP = 2'h0,
		LP_STOP = 2'h1,
		LP_STBY = 2'h2
	} pmcs_lp_mode_t;

endpackage : pmcs_pkg

// File: include/pmcs_sync_if.sv
// carrier between the top and its input synchroniser
// assumes raw is driven by the top and synced read back by it
interface pmcs_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sync_side (input raw, output synced);
	modport user (output raw, input synced);
endinterface : pmcs_sync_if

// File: logic/pmcs_sync.sv
// two-flop synchroniser for every asynchronous input of the supervisor
// assumes one clock; the first stage feeds the second stage only
module pmcs_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	pmcs_sync_if.sync_side sif
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= sif.raw;
			sync_reg <= meta_reg;
		end
	end

	assign sif.synced = sync_reg;

endmodule : pmcs_sync

// File: logic/pmcs_top.sv
// power-mode and startup-clock supervisor with a classic wishbone register slave
// assumes pins and analog monitors are asynchronous, core and bus share clk_i
// Behaviour
// - sleep halts only processor clock, interrupts wake
// - stop halts core clocks, pll, oscillators except rc on peripheral request
// - stop regulator mode chosen by configuration
// - any event line wakes from stop
// - peripheral clock only after regulator back main
// - standby switches regulator, pll, oscillators off
// - standby left only on listed events
// - calendar and watchdog clocks never stop
// - regulator main after reset, low only stop
// - main supply monitors always hold reset when low, analog one unless disabled
// - analog supply monitor part disabled by option
// - software enabled supply detector raises edge interrupt
// - internal rc oscillator is clock after reset
// - failed external clock falls back, interrupts
// - programmable bus prescalers, software keeps limits
`include "pmcs_params.svh"

module pmcs_top import pmcs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic core_sleep_req_i,
	input wire logic core_irq_i,
	input wire logic [15:0] event_lines_i,
	input wire logic [1:0] analog_comparators_wake_i,
	input wire logic first_two_wire_port_wake_i,
	input wire logic first_serial_port_wake_i,
	input wire logic cec_wake_i,
	input wire logic calendar_event_i,
	input wire logic wake_pin_i,
	input wire logic external_reset_pin_n_i,
	input wire logic independent_watchdog_rst_i,
	input wire logic por_main_ok_i,
	input wire logic pdr_main_ok_i,
	input wire logic pdr_analog_ok_i,
	input wire logic analog_pdr_disable_i,
	input wire logic supply_above_i,
	input wire logic ext_clk_ok_i,
	input wire logic [2:0] periph_rc_req_i,
	output logic sys_rst_o,
	output logic cpu_clk_en_o,
	output logic core_clk_en_o,
	output logic pll_en_o,
	output logic rc_osc_en_o,
	output logic ext_osc_en_o,
	output logic sysclk_sel_o,
	output logic regulator_main_mode_o,
	output logic regulator_low_power_mode_o,
	output logic regulator_off_o,
	output logic [2:0] periph_rc_grant_o,
	output logic calendar_clk_en_o,
	output logic watchdog_clk_en_o,
	output logic supply_irq_o,
	output logic clk_fail_irq_o,
	output logic [3:0] ahb_div_o,
	output logic [2:0] apb_div_o,
	output logic [5:0] state_o
);

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	localparam int NA = 34;
	pmcs_sync_if #(.W(NA)) sif ();
	assign sif.raw = {periph_rc_req_i, analog_pdr_disable_i, ext_clk_ok_i, supply_above_i,
		pdr_analog_ok_i, pdr_main_ok_i, por_main_ok_i, independent_watchdog_rst_i,
		external_reset_pin_n_i, wake_pin_i, calendar_event_i, cec_wake_i,
		first_serial_port_wake_i, first_two_wire_port_wake_i, analog_comparators_wake_i,
		event_lines_i};
	pmcs_sync #(.W(NA)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sif(sif.sync_side)
	);

	wire [15:0] s_ev = sif.synced[15:0];
	wire [1:0] s_comp = sif.synced[17:16];
	wire s_twi = sif.synced[18];
	wire s_ser = sif.synced[19];
	wire s_cec = sif.synced[20];
	wire s_cal = sif.synced[21];
	wire s_wpin = sif.synced[22];
	wire s_external_reset_pin = sif.synced[23];
	wire s_wdg = sif.synced[24];
	wire s_por = sif.synced[25];
	wire s_pdr_main = sif.synced[26];
	wire s_pdr_ana = sif.synced[27];
	wire s_above = sif.synced[28];
	wire s_extok = sif.synced[29];
	wire s_ana_dis = sif.synced[30];
	wire [2:0] s_rcreq = sif.synced[33:31];

	// ----------------------------------------
	// state
	// ----------------------------------------
	pmcs_state_t state_reg, state_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [7:0] cnt_reg, cnt_next;
	logic main_ok_reg, main_ok_next;
	logic on_ext_reg, on_ext_next;
	logic pvd_flag_reg, pvd_flag_next;
	logic fail_flag_reg, fail_flag_next;
	logic wpin_prev_reg;
	logic above_prev_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;

	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	// the analog part of the power-down monitor can be masked by its option bit
	wire supply_bad = !s_por || !s_pdr_main || (!s_pdr_ana && !s_ana_dis);
	wire hard_rst = supply_bad || !s_external_reset_pin || s_wdg;
	wire in_stby = (state_reg == ST_STBY);
	wire wpin_rise = s_wpin && !wpin_prev_reg;
	wire stby_wake = in_stby && (wpin_rise || s_cal);
	// standby loses register contents, so leaving it reinitialises the state, the control register and the flags
	wire init = hard_rst || stby_wake;

	// ----------------------------------------
	// register bus decode
	// ----------------------------------------
	wire wb_req = wb_cyc_i && wb_stb_i;
	wire [7:0] wb_word = {wb_adr_i[7:2], 2'b00};
	wire hit_ctrl = (wb_word == `PMCS_ADR_CTRL);
	wire hit_stat = (wb_word == `PMCS_ADR_STAT);
	// writes land on the edge that the master samples ack on
	wire wb_wr = wb_req && wb_we_i && ack_reg;
	wire wr_ctrl = wb_wr && hit_ctrl;
	wire wr_stat = wb_wr && hit_stat;
	wire [15:0] ctrl_merged = {wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_reg[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_reg[7:0]};
	wire clr_pvd = wr_stat && wb_sel_i[1] && wb_dat_i[`PMCS_STAT_PVD_FLAG];
	wire clr_fail = wr_stat && wb_sel_i[1] && wb_dat_i[`PMCS_STAT_FAIL_FLAG];

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	wire [1:0] mode_bits = ctrl_reg[`PMCS_CTRL_MODE_LSB +: 2];
	wire stop_lp = ctrl_reg[`PMCS_CTRL_STOP_LP];
	wire pvd_en = ctrl_reg[`PMCS_CTRL_PVD_EN];
	wire pvd_fall = ctrl_reg[`PMCS_CTRL_PVD_FALL];
	wire pvd_rise = ctrl_reg[`PMCS_CTRL_PVD_RISE];
	wire fail_ie = ctrl_reg[`PMCS_CTRL_FAIL_IE];
	wire ext_sel = ctrl_reg[`PMCS_CTRL_EXT_SEL];
	wire pll_req = ctrl_reg[`PMCS_CTRL_PLL_EN];

	// ----------------------------------------
	// supply detector and clock failure
	// ----------------------------------------
	wire above_fell = above_prev_reg && !s_above;
	wire above_rose = !above_prev_reg && s_above;
	wire pvd_set = pvd_en && ((pvd_fall && above_fell) || (pvd_rise && above_rose));
	wire fail_set = on_ext_reg && !s_extok;
	wire active = (state_reg == ST_RUN) || (state_reg == ST_SLEEP);

	assign ctrl_next = init ? `PMCS_CTRL_RST : (wr_ctrl ? ctrl_merged : ctrl_reg);
	// a new event wins over a software clear in the same cycle
	assign pvd_flag_next = !init && (pvd_set || (pvd_flag_reg && !clr_pvd));
	assign fail_flag_next = !init && (fail_set || (fail_flag_reg && !clr_fail));
	// rc stays the clock until software asks and the external clock is healthy
	assign on_ext_next = !init && active && ext_sel && s_extok && !fail_flag_reg;

	// ----------------------------------------
	// mode sequencing
	// ----------------------------------------
	wire stop_wake = (|s_ev) || (|s_comp) || s_twi || s_ser || s_cec || s_cal
		|| (pvd_en && (above_fell || above_rose));
	wire rc_req_any = |s_rcreq;
	wire in_stop = (state_reg == ST_STOP);
	// a clock request in low-power stop pulls the regulator back to main first
	wire reg_boost = in_stop && stop_lp && rc_req_any;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (core_sleep_req_i) begin
					case (mode_bits)
						LP_STOP: state_next = ST_STOP;
						LP_STBY: state_next = ST_STBY;
						default: state_next = ST_SLEEP;
					endcase
				end
			end
			ST_SLEEP: begin
				if (core_irq_i || stop_wake) begin
					state_next = ST_RUN;
				end
			end
			ST_STOP: begin
				if (stop_wake) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (cnt_reg == 8'h00) begin
					state_next = ST_RUN;
				end
			end
			ST_STBY: state_next = ST_STBY;
			default: state_next = ST_RUN;
		endcase
		if (init) begin
			state_next = ST_RUN;
		end
	end

	// one counter serves both the regulator settle in stop and the rc restart
	always_comb begin
		cnt_next = cnt_reg;
		if (in_stop && stop_wake) begin
			cnt_next = 8'(`PMCS_RC_START_CYC);
		end else if (in_stop && !reg_boost) begin
			cnt_next = 8'(`PMCS_REG_SETTLE_CYC);
		end else if (cnt_reg != 8'h00) begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	assign main_ok_next = in_stop && (!stop_lp || (reg_boost && cnt_reg == 8'h00));

	// ----------------------------------------
	// output decode
	// ----------------------------------------
	wire in_wake = (state_reg == ST_WAKE);
	wire cpu_en_d = (state_reg == ST_RUN);
	wire core_en_d = active;
	wire pll_en_d = active && pll_req;
	wire ext_en_d = active && ext_sel;
	wire rc_en_d = active || in_wake || (in_stop && main_ok_reg && rc_req_any);
	wire reg_lp_d = in_stop && stop_lp && !reg_boost;
	wire reg_main_d = !in_stby && !reg_lp_d;
	wire [2:0] grant_d = (active || in_wake) ? s_rcreq
		: ((in_stop && main_ok_reg) ? s_rcreq : 3'h0);
	wire [31:0] stat_word = {20'h00000, 1'b0, fail_flag_reg, pvd_flag_reg, s_above,
		regulator_low_power_mode_o, on_ext_reg, state_reg};
	wire [31:0] rdata_d = hit_ctrl ? {16'h0000, ctrl_reg} : (hit_stat ? stat_word : 32'h00000000);

	// ----------------------------------------
	// flops
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_RUN;
			ctrl_reg <= `PMCS_CTRL_RST;
			cnt_reg <= 8'h00;
			main_ok_reg <= 1'b0;
			on_ext_reg <= 1'b0;
			pvd_flag_reg <= 1'b0;
			fail_flag_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			cnt_reg <= cnt_next;
			main_ok_reg <= main_ok_next;
			on_ext_reg <= on_ext_next;
			pvd_flag_reg <= pvd_flag_next;
			fail_flag_reg <= fail_flag_next;
		end
	end

	// edge memories belong to the always-on side and survive soft resets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wpin_prev_reg <= 1'b0;
			above_prev_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			wpin_prev_reg <= s_wpin;
			above_prev_reg <= s_above;
			ack_reg <= wb_req && !ack_reg;
			rdata_reg <= (wb_req && !ack_reg) ? rdata_d : rdata_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_rst_o <= 1'b1;
			cpu_clk_en_o <= 1'b0;
			core_clk_en_o <= 1'b0;
			pll_en_o <= 1'b0;
			rc_osc_en_o <= 1'b1;
			ext_osc_en_o <= 1'b0;
			sysclk_sel_o <= 1'b0;
			regulator_main_mode_o <= 1'b1;
			regulator_low_power_mode_o <= 1'b0;
			regulator_off_o <= 1'b0;
			periph_rc_grant_o <= 3'h0;
			calendar_clk_en_o <= 1'b1;
			watchdog_clk_en_o <= 1'b1;
			supply_irq_o <= 1'b0;
			clk_fail_irq_o <= 1'b0;
			ahb_div_o <= 4'h0;
			apb_div_o <= 3'h0;
			state_o <= 6'h01;
		end else begin
			sys_rst_o <= init;
			cpu_clk_en_o <= cpu_en_d;
			core_clk_en_o <= core_en_d;
			pll_en_o <= pll_en_d;
			rc_osc_en_o <= rc_en_d;
			ext_osc_en_o <= ext_en_d;
			sysclk_sel_o <= on_ext_reg;
			regulator_main_mode_o <= reg_main_d;
			regulator_low_power_mode_o <= reg_lp_d;
			regulator_off_o <= in_stby;
			periph_rc_grant_o <= grant_d;
			calendar_clk_en_o <= 1'b1;
			watchdog_clk_en_o <= 1'b1;
			supply_irq_o <= pvd_flag_reg;
			clk_fail_irq_o <= fail_flag_reg && fail_ie;
			ahb_div_o <= ctrl_reg[`PMCS_CTRL_AHB_LSB +: 4];
			apb_div_o <= ctrl_reg[`PMCS_CTRL_APB_LSB +: 3];
			state_o <= state_reg;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_sleep_cpu_only: assert property ((state_reg == ST_SLEEP) |=>
		(!cpu_clk_en_o && core_clk_en_o)) else $error("sleep clock gating wrong");
	a_stop_clocks_off: assert property (in_stop |=>
		(!core_clk_en_o && !pll_en_o && !ext_osc_en_o && !cpu_clk_en_o))
		else $error("clocks running in stop");
	a_stop_reg_lp: assert property ((in_stop && stop_lp && !rc_req_any) |=>
		(regulator_low_power_mode_o && !regulator_main_mode_o)) else $error("stop regulator");
	a_stop_event_wake: assert property ((in_stop && stop_wake && !init) |=>
		(state_reg == ST_WAKE)) else $error("stop missed wake event");
	a_grant_after_main: assert property ((in_stop && stop_lp && $rose(rc_req_any) && !init
		&& !stop_wake) |=> !main_ok_reg [*8]) else $error("clock granted before settle");
	a_grant_needs_main: assert property ((|periph_rc_grant_o) |->
		regulator_main_mode_o) else $error("grant while regulator low");
	a_stby_power_off: assert property (in_stby |=>
		(regulator_off_o && !rc_osc_en_o && !pll_en_o && !ext_osc_en_o))
		else $error("standby power not off");
	a_stby_only_exits: assert property ((in_stby && !init) |=> in_stby)
		else $error("standby left without event");
	a_calendar_kept: assert property (calendar_clk_en_o && watchdog_clk_en_o)
		else $error("always-on clock stopped");
	a_reset_main_reg: assert property ($fell(sys_rst_o) |->
		(regulator_main_mode_o && !regulator_low_power_mode_o)) else $error("regulator after reset");
	a_supply_holds: assert property (supply_bad |=> sys_rst_o)
		else $error("low supply not held in reset");
	a_analog_masked: assert property ((!s_pdr_ana && s_ana_dis && s_por && s_pdr_main
		&& s_external_reset_pin && !s_wdg && !stby_wake) |=> !sys_rst_o) else $error("analog monitor not masked");
	a_supply_irq: assert property (pvd_set && !init |=> pvd_flag_reg ##1 supply_irq_o)
		else $error("supply detector event lost");
	a_reset_rc_clock: assert property (sys_rst_o |=> !sysclk_sel_o)
		else $error("not on rc after reset");
	a_fail_fallback: assert property (fail_set && !init |=>
		(!on_ext_reg && fail_flag_reg) ##1 !sysclk_sel_o) else $error("no clock fallback");
	a_prescale_out: assert property (wr_ctrl && !init && wb_sel_i[1] |=> ##1
		(ahb_div_o == $past(wb_dat_i[11:8], 2))) else $error("prescaler not applied");
	a_sleep_entry: assert property ((state_reg == ST_RUN) && !core_sleep_req_i && !init
		|=> (state_reg == ST_RUN)) else $error("low power entered without request");
	a_wake_on_rc: assert property (in_wake |=> (rc_osc_en_o && !sysclk_sel_o))
		else $error("wake not on rc");
	a_bus_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

	c_stop_wake: cover property (in_stop ##1 in_wake ##[1:60] (state_reg == ST_RUN));
	c_stby_exit: cover property (in_stby ##1 sys_rst_o);
	c_boost_grant: cover property (reg_boost ##[1:20] (|periph_rc_grant_o));
	c_clk_fail: cover property (fail_set ##2 clk_fail_irq_o);

endmodule : pmcs_top

// File: test/pmcs_partner.sv
// far side model: processor core, wake sources, rc clock requests, external clock
// assumes pulse is entered just after a rising edge of clk_i
module pmcs_partner (
	input wire logic clk_i,
	output logic sleep_req_o,
	output logic irq_o,
	output logic [21:0] src_o,
	output logic [2:0] rc_req_o,
	output logic wake_pin_o,
	output logic ext_ok_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ev: [15:0] pins, [17:16] comparators, 18 two-wire, 19 serial, 20 cec,
	// 21 calendar, 22 core sleep request, 23 core interrupt,
	// [26:24] rc clock requests, 27 wake pin, 28 external clock healthy
	logic [28:0] ev;
	assign src_o = ev[21:0];
	assign sleep_req_o = ev[22];
	assign irq_o = ev[23];
	assign rc_req_o = ev[26:24];
	assign wake_pin_o = ev[27];
	assign ext_ok_o = ev[28];
	initial begin
		ev = 29'h10000000;
	end
	// one driver for every far-side line: the bench sets levels through here
	task set(input int i, input logic v);
		ev[i] <= v;
	endtask : set
	// held n cycles, then one idle edge; the two-flop sampling keeps any level held a whole cycle
	task pulse(input int i, input int n);
		ev[i] <= 1'b1;
		repeat (n) @(posedge clk_i);
		ev[i] <= 1'b0;
		@(posedge clk_i);
	endtask : pulse
endmodule : pmcs_partner

// File: test/pmcs_top_tb.sv
// self-checking bench of the power-mode and clock supervisor
// assumes pmcs_pkg compiled first and pmcs_params.svh on the include path
`include "pmcs_params.svh"
module pmcs_top_tb import pmcs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] SM = 7'h3F;
	localparam logic [6:0] RM = 7'h40;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, core_sleep_req_i, core_irq_i;
	logic wake_pin_i, external_reset_pin_n_i, independent_watchdog_rst_i, por_main_ok_i;
	logic pdr_main_ok_i, pdr_analog_ok_i, analog_pdr_disable_i, supply_above_i, ext_clk_ok_i;
	logic sys_rst_o, cpu_clk_en_o, core_clk_en_o, pll_en_o, rc_osc_en_o, ext_osc_en_o;
	logic sysclk_sel_o, regulator_main_mode_o, regulator_low_power_mode_o, regulator_off_o;
	logic calendar_clk_en_o, watchdog_clk_en_o, supply_irq_o, clk_fail_irq_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, ahb_div_o;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [21:0] src;
	logic [2:0] periph_rc_req_i, periph_rc_grant_o, apb_div_o;
	logic [5:0] state_o;
	int fails, checked;
	pmcs_partner pm (.clk_i, .sleep_req_o(core_sleep_req_i), .irq_o(core_irq_i), .src_o(src),
		.rc_req_o(periph_rc_req_i), .wake_pin_o(wake_pin_i), .ext_ok_o(ext_clk_ok_i));
	pmcs_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .core_sleep_req_i, .core_irq_i,
		.event_lines_i(src[15:0]), .analog_comparators_wake_i(src[17:16]),
		.first_two_wire_port_wake_i(src[18]), .first_serial_port_wake_i(src[19]),
		.cec_wake_i(src[20]), .calendar_event_i(src[21]), .wake_pin_i, .external_reset_pin_n_i,
		.independent_watchdog_rst_i, .por_main_ok_i, .pdr_main_ok_i, .pdr_analog_ok_i,
		.analog_pdr_disable_i, .supply_above_i, .ext_clk_ok_i, .periph_rc_req_i, .sys_rst_o,
		.cpu_clk_en_o, .core_clk_en_o, .pll_en_o, .rc_osc_en_o, .ext_osc_en_o, .sysclk_sel_o,
		.regulator_main_mode_o, .regulator_low_power_mode_o, .regulator_off_o,
		.periph_rc_grant_o, .calendar_clk_en_o, .watchdog_clk_en_o, .supply_irq_o,
		.clk_fail_irq_o, .ahb_div_o, .apb_div_o, .state_o);
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task finish_test();
		$display("checked %0d failed %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// request held until ack is sampled high; the two extra idle edges let outputs settle
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		chk("ack", wb_ack_o, 1'b1);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		repeat (2) @(posedge clk_i);
	endtask : wb
	task wr(input logic [31:0] d);
		wb(1'b1, `PMCS_ADR_CTRL, d);
	endtask : wr
	// waits on {sys_rst_o, state_o} under a mask
	task wt(input logic [6:0] m, input logic [6:0] v);
		int n;
		n = 0;
		while (({sys_rst_o, state_o} & m) !== v && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("wait", {sys_rst_o, state_o} & m, v);
	endtask : wt
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset();
		chk("regulator", {regulator_main_mode_o, regulator_low_power_mode_o}, 2'b10);
		chk("rc clock", {rc_osc_en_o, sysclk_sel_o, pll_en_o}, 3'b100);
		chk("always on", {calendar_clk_en_o, watchdog_clk_en_o}, 2'b11);
		$display("reset test done");
	endtask : t_reset
	task t_regs();
		wr(32'h0000_5B00);
		chk("ahb div", ahb_div_o, 4'hB);
		chk("apb div", apb_div_o, 3'h5);
		wb(1'b0, `PMCS_ADR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h0000_5B00);
		wb(1'b1, 8'h08, 32'h0000_FFFF);
		wb(1'b0, 8'h08, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b0, `PMCS_ADR_STAT, 32'h0);
		chk("status", rd[8:0], 9'h101);
		$display("register test done");
	endtask : t_regs
	task t_sleep();
		pm.pulse(22, 1);
		wt(SM, ST_SLEEP);
		chk("sleep clocks", {cpu_clk_en_o, core_clk_en_o}, 2'b01);
		pm.pulse(23, 1);
		wt(SM, ST_RUN);
		chk("cpu clock", cpu_clk_en_o, 1'b1);
		$display("sleep test done");
	endtask : t_sleep
	task t_stop();
		int idx[8] = '{0, 15, 16, 17, 18, 19, 20, 21};
		for (int i = 0; i < 8; i++) begin
			wr(32'h0000_8001 | (32'(i[0]) << `PMCS_CTRL_STOP_LP));
			pm.pulse(22, 1);
			wt(SM, ST_STOP);
			chk("stop clocks", {cpu_clk_en_o, core_clk_en_o, pll_en_o, rc_osc_en_o}, 4'h0);
			chk("stop ext", ext_osc_en_o, 1'b0);
			chk("stop reg", {regulator_main_mode_o, regulator_low_power_mode_o}, {~i[0], i[0]});
			chk("always on", {calendar_clk_en_o, watchdog_clk_en_o}, 2'b11);
			pm.pulse(idx[i], 4);
			wt(SM, ST_WAKE);
			wt(SM, ST_RUN);
			chk("wake clock", {rc_osc_en_o, sysclk_sel_o}, 2'b10);
		end
		$display("stop test done");
	endtask : t_stop
	task t_rc();
		int n, m;
		n = 0;
		m = 0;
		wr(32'h5);
		pm.pulse(22, 1);
		wt(SM, ST_STOP);
		pm.set(25, 1'b1);
		do begin
			@(posedge clk_i);
			n++;
			if (m == 0 && regulator_main_mode_o === 1'b1) m = n;
		end while (periph_rc_grant_o !== 3'b010 && n < 100);
		chk("rc grant", periph_rc_grant_o, 3'b010);
		chk("main first", (m > 0 && n - m >= 9), 1'b1);
		pm.set(25, 1'b0);
		pm.pulse(0, 4);
		wt(SM, ST_RUN);
		$display("rc request test done");
	endtask : t_rc
	task t_stby();
		for (int k = 0; k < 4; k++) begin
			wr(32'h2);
			pm.pulse(22, 1);
			wt(SM, ST_STBY);
			chk("standby", {regulator_off_o, regulator_main_mode_o, regulator_low_power_mode_o}, 3'h4);
			chk("stby clocks", {pll_en_o, rc_osc_en_o, ext_osc_en_o, core_clk_en_o}, 4'h0);
			chk("always on", {calendar_clk_en_o, watchdog_clk_en_o}, 2'b11);
			pm.pulse(0, 4);
			pm.pulse(23, 1);
			chk("stby held", state_o, ST_STBY);
			if (k == 0) pm.set(27, 1'b1);
			if (k == 1) pm.set(21, 1'b1);
			external_reset_pin_n_i <= (k != 2);
			independent_watchdog_rst_i <= (k == 3);
			wt(RM, RM);
			pm.set(27, 1'b0);
			pm.set(21, 1'b0);
			external_reset_pin_n_i <= 1'b1;
			independent_watchdog_rst_i <= 1'b0;
			wt(RM, 7'h00);
			chk("stby exit", state_o, ST_RUN);
			wb(1'b0, `PMCS_ADR_CTRL, 32'h0);
			chk("ctrl lost", rd, 32'h0);
		end
		$display("standby test done");
	endtask : t_stby
	task t_supply();
		analog_pdr_disable_i <= 1'b1;
		pdr_analog_ok_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk("analog masked", sys_rst_o, 1'b0);
		analog_pdr_disable_i <= 1'b0;
		wt(RM, RM);
		pdr_analog_ok_i <= 1'b1;
		wt(RM, 7'h00);
		for (int j = 0; j < 2; j++) begin
			{por_main_ok_i, pdr_main_ok_i} <= j ? 2'b10 : 2'b01;
			wt(RM, RM);
			repeat (30) @(posedge clk_i);
			chk("held", sys_rst_o, 1'b1);
			{por_main_ok_i, pdr_main_ok_i} <= 2'b11;
			wt(RM, 7'h00);
		end
		$display("supply monitor test done");
	endtask : t_supply
	task t_pvd();
		supply_above_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("off irq", supply_irq_o, 1'b0);
		supply_above_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int e = 0; e < 2; e++) begin
			wr(e ? 32'h28 : 32'h18);
			supply_above_i <= e[0];
			repeat (8) @(posedge clk_i);
			chk("supply irq", supply_irq_o, 1'b1);
			wb(1'b1, `PMCS_ADR_STAT, 32'h200);
			chk("irq clear", supply_irq_o, 1'b0);
		end
		$display("detector test done");
	endtask : t_pvd
	task t_fail();
		for (int f = 0; f < 2; f++) begin
			wr(32'h80 | (f ? 32'h40 : 32'h0));
			repeat (6) @(posedge clk_i);
			chk("on external", {sysclk_sel_o, ext_osc_en_o}, 2'b11);
			pm.set(28, 1'b0);
			repeat (8) @(posedge clk_i);
			chk("fall back", {sysclk_sel_o, rc_osc_en_o, clk_fail_irq_o}, {2'b01, f[0]});
			pm.set(28, 1'b1);
			wb(1'b1, `PMCS_ADR_STAT, 32'h400);
			chk("fail clear", clk_fail_irq_o, 1'b0);
		end
		wr(32'h0);
		$display("clock fail test done");
	endtask : t_fail
	initial begin
		{rst_i, external_reset_pin_n_i, por_main_ok_i, pdr_main_ok_i} = 4'hF;
		{pdr_analog_ok_i, supply_above_i, independent_watchdog_rst_i, analog_pdr_disable_i} = 4'hC;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'h3;
		fails = 0;
		checked = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wt(RM, 7'h00);
		t_reset();
		t_regs();
		t_sleep();
		t_stop();
		t_rc();
		t_stby();
		t_supply();
		t_pvd();
		t_fail();
		finish_test();
	end
	// the whole run needs about a thousand cycles; this allows some thirty times that
	initial begin
		#(50 * 30000);
		fails++;
		finish_test();
	end
endmodule : pmcs_top_tb
